/* File: hdl/osdmap_pkg.sv */
`default_nettype none

package osdmap_pkg;

  // ---------------------------------------------------------------
  // Register map (word indexes, byte address is four times index)
  // ---------------------------------------------------------------
  localparam logic [9:0] CHARSET_IDX = 10'h0f5;
  localparam logic [9:0] BLKPTR_IDX = 10'h0fc;
  localparam logic [9:0] MODE_IDX = 10'h0f0;
  localparam logic [9:0] STATUS_IDX = 10'h0f1;
  localparam logic [7:0] CHARSET_RESET = 8'h00;
  localparam logic [7:0] BLKPTR_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CHARSET_MAP_BIT = 4;
  localparam int CHARSET_BANK_BIT = 5;
  localparam int MODE_PAR_BIT = 0;
  localparam int MODE_W80_BIT = 1;
  localparam int MODE_LINE_BIT = 2;
  localparam int MODE_SCROLL_BIT = 3;
  localparam int MODE_G0HI_BIT = 4;

  // ---------------------------------------------------------------
  // Display memory layout
  // ---------------------------------------------------------------
  localparam logic [15:0] RAM_BASE = 16'h8000;
  localparam logic [15:0] KBLK_STEP = 16'h0400;
  localparam logic [15:0] HBLK_STEP = 16'h0200;
  localparam logic [15:0] HS_ATTR_OFS = 16'h0080;
  localparam logic [15:0] ROWTAB_OFS = 16'h0100;
  localparam logic [15:0] ROW_CHARS = 16'h0028;
  localparam logic [4:0] FULL_SCROLL_ROW = 5'h18;
  localparam logic [4:0] LINE_SCROLL_ROW = 5'h0c;
  localparam logic [3:0] ROWTAB_LEN = 4'hc;

  // ---------------------------------------------------------------
  // Font ROM layout
  // ---------------------------------------------------------------
  localparam logic [8:0] G0_SET1_BASE = 9'h100;
  localparam logic [8:0] G0_SET2_BASE = 9'h160;
  localparam logic [8:0] NAT_BASE = 9'h100;
  localparam logic [8:0] NAT_LEN = 9'h00d;
  localparam logic [8:0] EXT_HI_BASE = 9'h1c0;
  localparam logic [8:0] EXT_HI_FIRST = 9'h0a0;
  localparam logic [8:0] G0_FIRST = 9'h020;

  // Kinds of display memory fetch
  typedef enum logic [2:0] {
    OSDMAP_PAGE_CHAR,
    OSDMAP_PAGE_ATTR,
    OSDMAP_HS_CHAR,
    OSDMAP_HS_ATTR,
    OSDMAP_ROW_TAB,
    OSDMAP_SCROLL
  } osdmap_kind_type;

  typedef struct packed {
    osdmap_kind_type kind;
    logic [4:0] row;
    logic [5:0] col;
    logic right;
  } osdmap_fetch_type;

  typedef struct packed {
    logic [8:0] code;
    logic serial_mosaic;
    logic serial_separated;
    logic [1:0] shape;
  } osdmap_glyph_type;

  typedef struct packed {
    logic [7:0] charset;
    logic [7:0] blkptr;
    logic [7:0] mode;
    logic ram_valid;
    logic [15:0] ram_addr;
    logic font_valid;
    logic [9:0] font_addr;
    logic font_mosaic;
    logic font_separated;
  } osdmap_state_type;

endpackage : osdmap_pkg

`default_nettype wire

/* File: hdl/osdmap_core.sv */
`default_nettype none

module osdmap_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire osdmap_pkg::osdmap_fetch_type fetch_req,
  output logic ram_valid,
  output logic [15:0] ram_addr,
  input wire logic glyph_valid,
  input wire osdmap_pkg::osdmap_glyph_type glyph_req,
  output logic font_valid,
  output logic [9:0] font_addr,
  output logic font_mosaic,
  output logic font_separated
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Position of a code among the 13 nationally varying G0 codes
  function automatic logic [3:0] osdmap_nat_pos(input logic [7:0] c);
    unique case (c)
      8'h23: osdmap_nat_pos = 4'd0;
      8'h24: osdmap_nat_pos = 4'd1;
      8'h40: osdmap_nat_pos = 4'd2;
      8'h5b: osdmap_nat_pos = 4'd3;
      8'h5c: osdmap_nat_pos = 4'd4;
      8'h5d: osdmap_nat_pos = 4'd5;
      8'h5e: osdmap_nat_pos = 4'd6;
      8'h5f: osdmap_nat_pos = 4'd7;
      8'h60: osdmap_nat_pos = 4'd8;
      8'h7b: osdmap_nat_pos = 4'd9;
      8'h7c: osdmap_nat_pos = 4'd10;
      8'h7d: osdmap_nat_pos = 4'd11;
      8'h7e: osdmap_nat_pos = 4'd12;
      default: osdmap_nat_pos = 4'hf;
    endcase
  endfunction : osdmap_nat_pos

  // Word index of an APB address, or all ones when misaligned
  function automatic logic [9:0] osdmap_index(input logic [11:0] a);
    osdmap_index = (a[1:0] == 2'b00) ? a[11:2] : 10'h3ff;
  endfunction : osdmap_index

  osdmap_pkg::osdmap_state_type st_r;
  osdmap_pkg::osdmap_state_type st_nxt;

  logic [9:0] idx;
  logic mapped;
  logic [15:0] page_base;
  logic [15:0] hs_base;
  logic [15:0] row_ofs;
  logic [4:0] row_eff;
  logic [8:0] rom_addr;
  logic is_mosaic;
  logic is_sep;
  logic [3:0] nat_pos;
  logic [3:0] subset;
  logic [1:0] g0_set;
  logic par;
  logic w80;
  logic line;

  // ---------------------------------------------------------------
  // Register decode; the slave never stalls
  // ---------------------------------------------------------------
  assign idx = osdmap_index(paddr);
  assign mapped = (idx == osdmap_pkg::CHARSET_IDX) || (idx == osdmap_pkg::BLKPTR_IDX) ||
                  (idx == osdmap_pkg::MODE_IDX) || (idx == osdmap_pkg::STATUS_IDX);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data is a mux of flops only, so it is stable through the access
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (idx)
      osdmap_pkg::CHARSET_IDX: prdata = {24'h00_0000, st_r.charset};
      osdmap_pkg::BLKPTR_IDX: prdata = {24'h00_0000, st_r.blkptr};
      osdmap_pkg::MODE_IDX: prdata = {24'h00_0000, st_r.mode};
      osdmap_pkg::STATUS_IDX: prdata = {6'h00, st_r.font_addr, st_r.ram_addr};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Display memory address generation
  // ---------------------------------------------------------------
  assign par = st_r.mode[osdmap_pkg::MODE_PAR_BIT] && !st_r.mode[osdmap_pkg::MODE_W80_BIT];
  assign w80 = st_r.mode[osdmap_pkg::MODE_W80_BIT];
  assign line = st_r.mode[osdmap_pkg::MODE_LINE_BIT];
  // Pointer n sits at n half-kilobyte steps above the RAM base
  assign page_base = osdmap_pkg::RAM_BASE + {3'h0, st_r.blkptr[3:0], 9'h000};
  assign hs_base = osdmap_pkg::RAM_BASE + {3'h0, st_r.blkptr[7:4], 9'h000};

  // Scroll buffer is the row just past the last displayed one
  always_comb begin
    row_eff = fetch_req.row;
    if (fetch_req.kind == osdmap_pkg::OSDMAP_SCROLL) begin
      row_eff = line ? osdmap_pkg::LINE_SCROLL_ROW : osdmap_pkg::FULL_SCROLL_ROW;
    end
  end

  assign row_ofs = 16'(row_eff * osdmap_pkg::ROW_CHARS) + {10'h000, fetch_req.col};

  // ---------------------------------------------------------------
  // Font ROM mapping
  // ---------------------------------------------------------------
  // Only bit 8 exists in parallel; serial codes are taken as 8 bits
  always_comb begin
    logic [8:0] code;
    logic css;
    code = par ? glyph_req.code : {1'b0, glyph_req.code[7:0]};
    css = par && code[8];
    subset = st_r.charset[3:0];
    g0_set = st_r.mode[osdmap_pkg::MODE_G0HI_BIT] ? subset[3:2] : subset[1:0];
    nat_pos = osdmap_nat_pos(code[7:0]);
    rom_addr = {1'b0, code[7:0]};
    is_mosaic = 1'b0;
    is_sep = 1'b0;
    if (css && code[7:5] == 3'b111) begin
      rom_addr = {4'h0, code[4:0]};
    end else if (css && {1'b0, code[7:0]} >= osdmap_pkg::EXT_HI_FIRST) begin
      // Codes A0h to DFh fill the top 64 slots in order; 80h to 9Fh stay mosaics
      rom_addr = osdmap_pkg::EXT_HI_BASE +
                 ({1'b0, code[7:0]} - osdmap_pkg::EXT_HI_FIRST);
    end else if (css || (!par && glyph_req.serial_mosaic)) begin
      // Mosaic cells are drawn by logic; address is left at the code
      is_mosaic = 1'b1;
      is_sep = par ? glyph_req.shape[1] : glyph_req.serial_separated;
    end else if (code[7:5] != 3'b000 && !code[7]) begin
      if (st_r.charset[osdmap_pkg::CHARSET_MAP_BIT]) begin
        unique case (g0_set)
          2'd1: rom_addr = osdmap_pkg::G0_SET1_BASE + ({1'b0, code[7:0]} - osdmap_pkg::G0_FIRST);
          2'd2: rom_addr = osdmap_pkg::G0_SET2_BASE + ({1'b0, code[7:0]} - osdmap_pkg::G0_FIRST);
          default: rom_addr = {1'b0, code[7:0]};
        endcase
      end else if (nat_pos != 4'hf && subset != 4'h0 && subset != 4'hf) begin
        // Subset 15 is not defined, so it falls back to the basic set
        rom_addr = osdmap_pkg::NAT_BASE + 9'((subset - 4'h1) * osdmap_pkg::NAT_LEN)
                   + {5'h00, nat_pos};
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ram_valid = 1'b0;
    st_nxt.font_valid = 1'b0;
    if (psel && penable && pwrite) begin
      unique case (idx)
        osdmap_pkg::CHARSET_IDX: st_nxt.charset = pwdata[7:0];
        osdmap_pkg::BLKPTR_IDX: st_nxt.blkptr = pwdata[7:0];
        osdmap_pkg::MODE_IDX: st_nxt.mode = pwdata[7:0];
        default: st_nxt.charset = st_r.charset;
      endcase
    end
    if (fetch_valid) begin
      st_nxt.ram_valid = 1'b1;
      unique case (fetch_req.kind)
        osdmap_pkg::OSDMAP_PAGE_CHAR, osdmap_pkg::OSDMAP_SCROLL: begin
          // Right half of 80-column rows lies one block higher
          st_nxt.ram_addr = page_base + row_ofs;
          if (w80 && fetch_req.right) begin
            st_nxt.ram_addr = page_base + row_ofs +
                              (line ? osdmap_pkg::HBLK_STEP : osdmap_pkg::KBLK_STEP);
          end
        end
        osdmap_pkg::OSDMAP_PAGE_ATTR: begin
          st_nxt.ram_addr = page_base + row_ofs +
                            (line ? osdmap_pkg::HBLK_STEP : osdmap_pkg::KBLK_STEP);
        end
        osdmap_pkg::OSDMAP_HS_CHAR: st_nxt.ram_addr = hs_base + row_ofs;
        osdmap_pkg::OSDMAP_HS_ATTR: begin
          st_nxt.ram_addr = hs_base + osdmap_pkg::HS_ATTR_OFS + row_ofs;
        end
        osdmap_pkg::OSDMAP_ROW_TAB: begin
          // Table index is row bits 3:0; values 12 to 15 fall back to byte 0 of its 12 bytes
          st_nxt.ram_addr = hs_base + osdmap_pkg::ROWTAB_OFS +
                            ((fetch_req.row[3:0] < osdmap_pkg::ROWTAB_LEN) ?
                             {12'h000, fetch_req.row[3:0]} : 16'h0000);
        end
        default: st_nxt.ram_addr = st_r.ram_addr;
      endcase
    end
    if (glyph_valid) begin
      st_nxt.font_valid = 1'b1;
      st_nxt.font_addr = {st_r.charset[osdmap_pkg::CHARSET_BANK_BIT], rom_addr};
      st_nxt.font_mosaic = is_mosaic;
      st_nxt.font_separated = is_sep;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.charset <= osdmap_pkg::CHARSET_RESET;
      st_r.blkptr <= osdmap_pkg::BLKPTR_RESET;
      st_r.mode <= osdmap_pkg::MODE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ram_valid = st_r.ram_valid;
  assign ram_addr = st_r.ram_addr;
  assign font_valid = st_r.font_valid;
  assign font_addr = st_r.font_addr;
  assign font_mosaic = st_r.font_mosaic;
  assign font_separated = st_r.font_separated;

endmodule : osdmap_core

`default_nettype wire

/* File: tb/osdmap_ram_model.sv */
`default_nettype none
// ----
// Shared display RAM model
// ----
module osdmap_ram_model (
  input wire logic pclk,
  input wire logic ram_valid,
  input wire logic [15:0] ram_addr,
  output var logic [7:0] rd_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // Answers one cycle after the address; between reads the data toggles so stale data never looks valid
  always_ff @(posedge pclk) begin
    if (ram_valid) begin
      rd_data <= ram_addr[7:0] ^ ram_addr[15:8];
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : osdmap_ram_model
`default_nettype wire

/* File: tb/osdmap_checker.sv */
`default_nettype none
module osdmap_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic fetch_valid,
  input wire osdmap_pkg::osdmap_fetch_type fetch_req,
  input wire logic ram_valid,
  input wire logic [15:0] ram_addr,
  input wire logic glyph_valid,
  input wire osdmap_pkg::osdmap_glyph_type glyph_req,
  input wire logic font_valid,
  input wire logic [9:0] font_addr,
  input wire logic font_mosaic
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Shadow state
  // ----
  logic bank_r;
  logic [8:0] ofs_r;
  logic [8:0] row_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Offsets are kept one cycle so a check can compare against the request that caused it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_r <= 1'b0;
      ofs_r <= 9'h000;
      row_r <= 9'h000;
    end else begin
      ofs_r <= 9'(fetch_req.row * 40 + fetch_req.col);
      row_r <= 9'(fetch_req.row);
      if (psel && penable && pwrite && paddr == 12'h3d4) begin
        bank_r <= pwdata[5];
      end
    end
  end
  property p_fetch_ans; fetch_valid |=> ram_valid; endproperty
  a_fetch_ans: assert property (p_fetch_ans) else $error("ram answer missing");
  property p_fetch_quiet; !fetch_valid |=> !ram_valid; endproperty
  a_fetch_quiet: assert property (p_fetch_quiet) else $error("ram answer unasked");
  property p_glyph_ans; glyph_valid |=> font_valid && font_addr[9] == $past(bank_r); endproperty
  a_glyph_ans: assert property (p_glyph_ans) else $error("font answer or bank wrong");
  property p_glyph_quiet; !glyph_valid |=> !font_valid; endproperty
  a_glyph_quiet: assert property (p_glyph_quiet) else $error("font answer unasked");
  property p_window; ram_valid |-> ram_addr >= 16'h8000; endproperty
  a_window: assert property (p_window) else $error("ram address below base");
  property p_hs_char;
    fetch_valid && fetch_req.kind == osdmap_pkg::OSDMAP_HS_CHAR && fetch_req.row < 3
      |=> ram_addr[8:0] == ofs_r;
  endproperty
  a_hs_char: assert property (p_hs_char) else $error("status char address wrong");
  property p_hs_attr;
    fetch_valid && fetch_req.kind == osdmap_pkg::OSDMAP_HS_ATTR && fetch_req.row < 3
      |=> ram_addr[8:0] == ofs_r + 9'h080;
  endproperty
  a_hs_attr: assert property (p_hs_attr) else $error("status attr address wrong");
  property p_row_tab;
    fetch_valid && fetch_req.kind == osdmap_pkg::OSDMAP_ROW_TAB && fetch_req.row < 12
      |=> ram_addr[8:0] == 9'h100 + row_r;
  endproperty
  a_row_tab: assert property (p_row_tab) else $error("row table address wrong");
  property p_no_mosaic;
    glyph_valid && !glyph_req.serial_mosaic && !glyph_req.code[8] |=> !font_mosaic;
  endproperty
  a_no_mosaic: assert property (p_no_mosaic) else $error("mosaic without select");
  c_row_tab: cover property (fetch_valid && fetch_req.kind == osdmap_pkg::OSDMAP_ROW_TAB);
  c_css: cover property (glyph_valid && glyph_req.code[8]);
  c_mosaic: cover property (font_valid && font_mosaic);
endmodule : osdmap_checker
bind osdmap_core osdmap_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .fetch_valid(fetch_valid), .fetch_req(fetch_req), .ram_valid(ram_valid),
  .ram_addr(ram_addr), .glyph_valid(glyph_valid), .glyph_req(glyph_req),
  .font_valid(font_valid), .font_addr(font_addr), .font_mosaic(font_mosaic));
`default_nettype wire

/* File: tb/osd_display_memory_font_map_test.sv */
`default_nettype none
module osd_display_memory_font_map_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fetch_valid = 1'b0, glyph_valid = 1'b0, pready, pslverr, ram_valid, er;
  logic font_valid, font_mosaic, font_separated;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] ram_addr;
  logic [9:0] font_addr;
  logic [7:0] ram_rd;
  osdmap_pkg::osdmap_fetch_type fetch_req = '0;
  osdmap_pkg::osdmap_glyph_type glyph_req = '0;
  int err_total = 0, compares = 0;
  localparam logic [15:0] PB = 16'h8400;
  localparam logic [15:0] HB = 16'h9000;
  always #12.5 pclk = ~pclk;
  osdmap_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_valid(fetch_valid), .fetch_req(fetch_req),
    .ram_valid(ram_valid), .ram_addr(ram_addr), .glyph_valid(glyph_valid),
    .glyph_req(glyph_req), .font_valid(font_valid), .font_addr(font_addr),
    .font_mosaic(font_mosaic), .font_separated(font_separated));
  osdmap_ram_model u_ram (.pclk(pclk), .ram_valid(ram_valid), .ram_addr(ram_addr),
    .rd_data(ram_rd));
  // ----
  // Shared tasks
  // ----
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; the idle cycle first keeps two drives of psel out of one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      err_total++;
      give_verdict();
    end
  endtask : apb
  // Kinds: 0 page char, 1 page attr, 2 status char, 3 status attr, 4 row table, 5 scroll
  task automatic fetch(input logic [7:0] md, input logic [2:0] k, input logic [4:0] r,
                       input logic [5:0] c, input logic rt, input logic [15:0] exp);
    apb(1'b1, 12'h3c0, {24'h00_0000, md});
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_req <= {k, r, c, rt};
    @(posedge pclk);
    fetch_valid <= 1'b0;
    #1;
    chk(ram_valid, 32'h0000_0001);
    chk(ram_addr, exp);
    // The shared RAM answers one cycle after the address
    @(posedge pclk);
    #1;
    chk({24'h00_0000, ram_rd}, {24'h00_0000, exp[7:0] ^ exp[15:8]});
  endtask : fetch
  // Flags are serial mosaic, serial separated, then the two shape bits
  // Every font region hit here stands loaded by software
  task automatic glyph(input logic [7:0] nc, input logic [7:0] md, input logic [8:0] code,
                       input logic [3:0] fl, input logic [9:0] exp, input logic [1:0] ms);
    apb(1'b1, 12'h3d4, {24'h00_0000, nc});
    apb(1'b1, 12'h3c0, {24'h00_0000, md});
    @(posedge pclk);
    glyph_valid <= 1'b1;
    glyph_req <= {code, fl};
    @(posedge pclk);
    glyph_valid <= 1'b0;
    #1;
    chk({font_valid, font_addr}, {1'b1, exp});
    chk({font_mosaic, font_separated}, ms);
  endtask : glyph
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h3d4, 32'h0000_0000); chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h3f0, 32'h0000_0000); chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h3d4, 32'hffff_ff35);
    apb(1'b0, 12'h3d4, 32'h0000_0000); chk(rd, 32'h0000_0035);
    apb(1'b0, 12'h004, 32'h0000_0000); chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    apb(1'b1, 12'h3c4, 32'hffff_ffff); chk({31'h0000_0000, er}, 32'h0000_0000);
    $display("Test registers done");
    apb(1'b1, 12'h3f0, 32'h0000_0082);
    fetch(8'h00, 3'd0, 5'd23, 6'd39, 1'b0, PB + 16'h03bf);
    fetch(8'h08, 3'd5, 5'd0, 6'd0, 1'b0, PB + 16'h03c0);
    fetch(8'h00, 3'd2, 5'd2, 6'd5, 1'b0, HB + 16'h0055);
    fetch(8'h01, 3'd1, 5'd1, 6'd1, 1'b0, PB + 16'h0429);
    fetch(8'h01, 3'd3, 5'd0, 6'd3, 1'b0, HB + 16'h0083);
    fetch(8'h04, 3'd0, 5'd11, 6'd0, 1'b0, PB + 16'h01b8);
    fetch(8'h04, 3'd4, 5'd11, 6'd0, 1'b0, HB + 16'h010b);
    fetch(8'h0c, 3'd5, 5'd0, 6'd7, 1'b0, PB + 16'h01e7);
    fetch(8'h05, 3'd1, 5'd0, 6'd0, 1'b0, PB + 16'h0200);
    fetch(8'h02, 3'd0, 5'd0, 6'd0, 1'b1, PB + 16'h0400);
    fetch(8'h06, 3'd0, 5'd3, 6'd2, 1'b1, PB + 16'h027a);
    apb(1'b0, 12'h3c4, 32'h0000_0000); chk(rd, 32'h0000_867a);
    $display("Test memory map done");
    glyph(8'h10, 8'h00, 9'h041, 4'h0, 10'h041, 2'b00);
    glyph(8'h11, 8'h00, 9'h041, 4'h0, 10'h121, 2'b00);
    glyph(8'h12, 8'h00, 9'h041, 4'h0, 10'h181, 2'b00);
    glyph(8'h18, 8'h10, 9'h041, 4'h0, 10'h181, 2'b00);
    glyph(8'h32, 8'h00, 9'h041, 4'h0, 10'h381, 2'b00);
    glyph(8'h02, 8'h00, 9'h040, 4'h0, 10'h10f, 2'b00);
    glyph(8'h02, 8'h00, 9'h041, 4'h0, 10'h041, 2'b00);
    glyph(8'h00, 8'h01, 9'h1e5, 4'h0, 10'h005, 2'b00);
    glyph(8'h00, 8'h01, 9'h1a0, 4'h0, 10'h1c0, 2'b00);
    glyph(8'h00, 8'h01, 9'h1df, 4'h0, 10'h1ff, 2'b00);
    glyph(8'h00, 8'h03, 9'h1e5, 4'h0, 10'h0e5, 2'b00);
    glyph(8'h00, 8'h00, 9'h1e5, 4'h0, 10'h0e5, 2'b00);
    glyph(8'h00, 8'h00, 9'h045, 4'hc, 10'h045, 2'b11);
    glyph(8'h00, 8'h01, 9'h145, 4'h2, 10'h045, 2'b11);
    glyph(8'h00, 8'h01, 9'h0a0, 4'h0, 10'h0a0, 2'b00);
    $display("Test font map done");
    // Mid-run reset must bring the pointers back to zero
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h3f0, 32'h0000_0000); chk(rd, 32'h0000_0000);
    $display("Test reset done");
    give_verdict();
  end
endmodule : osd_display_memory_font_map_test
`default_nettype wire
